// [hdl/prd_pkg.sv]
// Purpose: shared constants and types for the return/dispatch sequencer
// Assumes: 16-bit words, word addressing, bit 15 is the leftmost (bit 0) bit
// Notes: field positions count from the least significant bit
`default_nettype none
package prd_pkg;
	localparam int W = 16;
	// Status word layout
	localparam int ST_PRIV = 15;
	localparam int ST_EXTI = 14;
	localparam int ST_CC_HI = 9;
	localparam int ST_CC_LO = 8;
	localparam logic [7:0] ISR_SEGMENT = 8'h01;
	localparam logic [1:0] COND_GREATER_CODE = 2'h0;
	localparam logic [1:0] COND_EQUAL_CODE = 2'h2;
	// Label layout
	localparam int LBL_EXT = 15;
	localparam int LBL_STT_HI = 14;
	localparam int LBL_STT_LO = 8;
	localparam int LBL_OFF_HI = 13;
	// Marker: four words, lowest address first
	localparam logic [W-1:0] MARK_WORDS = 16'h0004;
	localparam logic [1:0] MK_X = 2'h0;
	localparam logic [1:0] MK_DP = 2'h1;
	localparam logic [1:0] MK_ST = 2'h2;
	localparam logic [1:0] MK_DQ = 2'h3;
	localparam int DP_TRACE = 15;
	localparam int QW_SCHED = 15;
	localparam logic [W-1:0] DEV_OFS = 16'h0003;
	// Interrupt stack base word and hold counter
	localparam logic [W-1:0] ISB_PTR_ADD = 16'h0001;
	localparam logic [W-1:0] HOLD_OFS = 16'h0012;
	localparam int ISB_PEND = 15;
	// Code segment table: count word, then 4-word entries (flags, base, limit)
	localparam logic [W-1:0] CSEG_TABLE_BASE = 16'h0000;
	localparam logic [1:0] CSEG_STRIDE_SH = 2'h2;
	localparam int CF_ABSENT = 15;
	localparam int CF_PRIV = 14;
	localparam int CF_REF = 13;
	localparam int CF_TRACE = 12;

	typedef enum logic [2:0] {PROCEDURE_CALL_OP, PROCEDURE_EXIT_OP, SCHEDULER_ENTRY_OP,
		SCHEDULER_HOLD_OP, SCHEDULER_RELEASE_OP, INTERRUPT_RETURN_OP} prd_op_t;
	typedef enum logic [2:0] {TRAP_NONE, TRAP_BOUNDS, TRAP_CSEG, TRAP_STT, TRAP_PRIV,
		TRAP_TAMPER, TRAP_ABSENT, TRAP_TRACE} prd_trap_t;
	typedef enum logic [2:0] {RT_NONE, RT_PROCESS, RT_LOWER_INT, RT_SCHED,
		RT_DISPATCH} prd_route_t;
endpackage
`default_nettype wire

// [hdl/prd_range_chk.sv]
// Purpose: inclusive address window check
// Assumes: unsigned 16-bit addresses
// Notes: combinational, caller registers the decision
`default_nettype none
module prd_range_chk
(
	// Window and address
	input wire logic [15:0] lo,
	input wire logic [15:0] hi,
	input wire logic [15:0] addr,
	// Result
	output logic in_range
);
	assign in_range = (addr >= lo) && (addr <= hi);
endmodule
`default_nettype wire

// [hdl/prd_return_dispatch.sv]
// Purpose: call tail, procedure return, scheduler entry/hold/release, interrupt return
// Assumes: memory answers each request with a one-cycle mem_ack
// Notes: register results appear on new_* with a commit pulse
`default_nettype none
module prd_return_dispatch
#(
	parameter logic [15:0] CSEG_BASE = prd_pkg::CSEG_TABLE_BASE
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Operation request
	input wire logic op_start,
	input wire prd_pkg::prd_op_t op_kind,
	input wire logic [7:0] op_count,
	input wire logic [15:0] op_label,
	// Current CPU state
	input wire logic [15:0] cur_p,
	input wire logic [15:0] cur_code_base,
	input wire logic [15:0] cur_code_limit,
	input wire logic [15:0] cur_q,
	input wire logic [15:0] cur_s,
	input wire logic [15:0] cur_x,
	input wire logic [15:0] cur_status,
	input wire logic [7:0] cpu_num,
	input wire logic on_interrupt_stack,
	input wire logic in_scheduler,
	// Memory path
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	// Results
	output logic busy,
	output logic done,
	output logic commit,
	output logic [15:0] new_p,
	output logic [15:0] new_code_base,
	output logic [15:0] new_code_limit,
	output logic [15:0] new_q,
	output logic [15:0] new_s,
	output logic [15:0] new_x,
	output logic [15:0] new_status,
	output logic trap,
	output prd_pkg::prd_trap_t trap_kind,
	output logic sched_entry,
	output prd_pkg::prd_route_t route,
	output logic rst_int,
	output logic [15:0] rst_int_dev
);
	import prd_pkg::*;

	typedef enum logic [3:0] {S_IDLE, S_CMARK, S_XMARK, S_CNT, S_ENT, S_REF, S_STT, S_CHK,
		S_BASE, S_QIW, S_HOLD, S_WHOLD, S_WBASE, S_DEV, S_QW} prd_state_t;

	prd_state_t state_r;
	prd_op_t kind_r;
	logic [15:0] p_r, cb_r, cl_r, q_r, s_r, x_r, st_r, a_r, flags_r, isb_r, hold_r, lbl_r, qiw_r;
	logic [15:0] mk_r [4];
	logic [7:0] n_r, seg_r;
	logic [1:0] idx_r;
	logic mem_req_r, mem_we_r, go_sched_r;
	logic [15:0] mem_addr_r, mem_wdata_r;
	logic busy_r, done_r, commit_r, trap_r, sched_r, rst_r;
	logic [15:0] np_r, ncb_r, ncl_r, nq_r, ns_r, nx_r, nst_r, dev_r;
	prd_trap_t trap_kind_r;
	prd_route_t route_r;
	logic in_rng;

	function automatic logic [15:0] isb_ptr(input logic [7:0] cpu);
		isb_ptr = 16'({cpu, 2'b00}) + ISB_PTR_ADD;
	endfunction

	function automatic logic [15:0] with_cc(input logic [15:0] st, input logic [1:0] cc);
		with_cc = st;
		with_cc[ST_CC_HI:ST_CC_LO] = cc;
	endfunction

	function automatic logic [15:0] cseg_entry(input logic [7:0] seg);
		cseg_entry = CSEG_BASE + 16'(({8'h00, seg} + 16'h0001) << CSEG_STRIDE_SH);
	endfunction

	prd_range_chk u_rng
	(
		.lo(cb_r),
		.hi(cl_r),
		.addr(a_r),
		.in_range(in_rng)
	);

	wire user_mode = !st_r[ST_PRIV];
	wire [15:0] call_top = s_r + MARK_WORDS;

	// Sequencer, memory port and results in one process: every step but S_IDLE, S_CHK and a write-free S_WBASE is a memory beat
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r <= S_IDLE;
			kind_r <= PROCEDURE_CALL_OP;
			{p_r, cb_r, cl_r, q_r, s_r, x_r, st_r, a_r} <= '0;
			{flags_r, isb_r, hold_r, lbl_r, qiw_r, n_r, seg_r, idx_r} <= '0;
			mk_r <= '{default: 16'h0000};
			{mem_req_r, mem_we_r, go_sched_r, mem_addr_r, mem_wdata_r} <= '0;
			{busy_r, done_r, commit_r, trap_r, sched_r, rst_r} <= '0;
			{np_r, ncb_r, ncl_r, nq_r, ns_r, nx_r, nst_r, dev_r} <= '0;
			trap_kind_r <= TRAP_NONE;
			route_r <= RT_NONE;
		end
		else
		begin
			done_r <= 1'b0;
			commit_r <= 1'b0;
			trap_r <= 1'b0;
			sched_r <= 1'b0;
			rst_r <= 1'b0;
			if (mem_ack)
				mem_req_r <= 1'b0;
			case (state_r)
				S_IDLE:
				if (op_start)
				begin
					busy_r <= 1'b1;
					kind_r <= op_kind;
					{p_r, cb_r, cl_r, q_r, s_r} <= {cur_p, cur_code_base, cur_code_limit, cur_q, cur_s};
					{x_r, st_r, n_r, lbl_r, idx_r} <= {cur_x, cur_status, op_count, op_label, 2'b00};
					trap_kind_r <= TRAP_NONE;
					route_r <= RT_NONE;
					go_sched_r <= 1'b0;
					mem_req_r <= 1'b1;
					case (op_kind)
						PROCEDURE_CALL_OP:
						begin
							// Marker goes above the stack top, X word first
							{mem_we_r, mem_addr_r, mem_wdata_r} <= {1'b1, cur_s + 16'h0001, cur_x};
							state_r <= S_CMARK;
						end
						PROCEDURE_EXIT_OP:
						begin
							{mem_we_r, mem_addr_r} <= {1'b0, cur_q - MARK_WORDS + 16'h0001};
							state_r <= S_XMARK;
						end
						default:
						begin
							{mem_we_r, mem_addr_r} <= {1'b0, isb_ptr(cpu_num)};
							state_r <= S_BASE;
						end
					endcase
				end
				S_CMARK:
				if (mem_ack)
				begin
					if (idx_r == MK_DQ)
					begin
						q_r <= call_top;
						s_r <= call_top;
						if (lbl_r[LBL_EXT])
						begin
							seg_r <= lbl_r[7:0];
							{mem_req_r, mem_we_r, mem_addr_r} <= {1'b1, 1'b0, CSEG_BASE};
							state_r <= S_CNT;
						end
						else
						begin
							a_r <= cb_r + {2'b00, lbl_r[LBL_OFF_HI:0]};
							state_r <= S_CHK;
						end
					end
					else
					begin
						idx_r <= idx_r + 2'h1;
						mem_req_r <= 1'b1;
						mem_addr_r <= s_r + 16'h0002 + {14'h0000, idx_r};
						case (idx_r + 2'h1)
							MK_DP: mem_wdata_r <= call_top - (p_r + 16'h0001);
							MK_ST: mem_wdata_r <= st_r;
							default: mem_wdata_r <= call_top - q_r;
						endcase
					end
				end
				S_XMARK:
				if (mem_ack)
				begin
					mk_r[idx_r] <= mem_rdata;
					idx_r <= idx_r + 2'h1;
					if (idx_r != MK_DQ)
						{mem_req_r, mem_addr_r} <= {1'b1, mem_addr_r + 16'h0001};
					else
					begin
						// In user mode, privileged/interrupt-enable bits must match the live status
						if (user_mode && (mk_r[MK_ST][ST_PRIV] != st_r[ST_PRIV]
							|| mk_r[MK_ST][ST_EXTI] != st_r[ST_EXTI]))
						begin
							{trap_r, done_r, busy_r, trap_kind_r} <= {3'b110, TRAP_TAMPER};
							state_r <= S_IDLE;
						end
						else if (mk_r[MK_ST][7:0] == st_r[7:0])
						begin
							a_r <= q_r - mk_r[MK_DP];
							state_r <= S_CHK;
						end
						else
						begin
							seg_r <= mk_r[MK_ST][7:0];
							{mem_req_r, mem_addr_r} <= {1'b1, CSEG_BASE};
							state_r <= S_CNT;
						end
					end
				end
				S_CNT:
				if (mem_ack)
				begin
					if ({8'h00, seg_r} >= mem_rdata)
					begin
						{trap_r, done_r, busy_r, trap_kind_r} <= {3'b110, TRAP_CSEG};
						state_r <= S_IDLE;
					end
					else
					begin
						idx_r <= 2'h0;
						{mem_req_r, mem_addr_r} <= {1'b1, cseg_entry(seg_r)};
						state_r <= S_ENT;
					end
				end
				S_ENT:
				if (mem_ack)
				begin
					idx_r <= idx_r + 2'h1;
					case (idx_r)
						2'h0: flags_r <= mem_rdata;
						2'h1: cb_r <= mem_rdata;
						default: cl_r <= mem_rdata;
					endcase
					if (idx_r != 2'h2)
						{mem_req_r, mem_addr_r} <= {1'b1, mem_addr_r + 16'h0001};
					else if (kind_r == PROCEDURE_EXIT_OP && user_mode && flags_r[CF_PRIV])
					begin
						{trap_r, done_r, busy_r, trap_kind_r} <= {3'b110, TRAP_PRIV};
						state_r <= S_IDLE;
					end
					else
					begin
						mem_req_r <= 1'b1;
						{mem_we_r, mem_addr_r} <= {1'b1, cseg_entry(seg_r)};
						mem_wdata_r <= flags_r | (16'h0001 << CF_REF);
						state_r <= S_REF;
					end
				end
				S_REF:
				if (mem_ack)
				begin
					mem_we_r <= 1'b0;
					if (kind_r == PROCEDURE_CALL_OP)
					begin
						st_r[ST_PRIV] <= st_r[ST_PRIV] | flags_r[CF_PRIV];
						st_r[7:0] <= seg_r;
					end
					if (flags_r[CF_ABSENT])
					begin
						{trap_r, done_r, busy_r, trap_kind_r} <= {3'b110, TRAP_ABSENT};
						state_r <= S_IDLE;
					end
					else if (kind_r == PROCEDURE_EXIT_OP ? mk_r[MK_DP][DP_TRACE] : flags_r[CF_TRACE])
					begin
						{trap_r, done_r, busy_r, trap_kind_r} <= {3'b110, TRAP_TRACE};
						state_r <= S_IDLE;
					end
					else if (kind_r == PROCEDURE_EXIT_OP)
					begin
						a_r <= q_r - mk_r[MK_DP];
						state_r <= S_CHK;
					end
					else if (lbl_r[LBL_STT_HI:LBL_STT_LO] == 7'h00)
					begin
						a_r <= cb_r;
						state_r <= S_CHK;
					end
					else
					begin
						{mem_req_r, mem_addr_r} <= {1'b1, cl_r - {9'h000, lbl_r[LBL_STT_HI:LBL_STT_LO]}};
						state_r <= S_STT;
					end
				end
				S_STT:
				if (mem_ack)
				begin
					if (mem_rdata[LBL_EXT])
					begin
						{trap_r, done_r, busy_r, trap_kind_r} <= {3'b110, TRAP_STT};
						state_r <= S_IDLE;
					end
					else
					begin
						a_r <= cb_r + {2'b00, mem_rdata[LBL_OFF_HI:0]};
						state_r <= S_CHK;
					end
				end
				S_CHK:
				begin
					state_r <= S_IDLE;
					done_r <= 1'b1;
					busy_r <= 1'b0;
					if (!in_rng)
						{trap_r, trap_kind_r} <= {1'b1, TRAP_BOUNDS};
					else if (kind_r == PROCEDURE_CALL_OP)
					begin
						commit_r <= 1'b1;
						{np_r, ncb_r, ncl_r, nq_r, ns_r} <= {a_r, cb_r, cl_r, q_r, s_r};
						{nx_r, nst_r} <= {x_r, st_r};
					end
					else
					begin
						commit_r <= 1'b1;
						{np_r, ncb_r, ncl_r, nx_r, nst_r} <= {a_r, cb_r, cl_r, mk_r[MK_X], mk_r[MK_ST]};
						nq_r <= q_r - mk_r[MK_DQ];
						ns_r <= q_r - MARK_WORDS - {8'h00, n_r};
					end
				end
				S_BASE:
				if (mem_ack)
				begin
					isb_r <= mem_rdata;
					{mem_req_r, mem_addr_r} <= {1'b1, mem_rdata};
					state_r <= S_QIW;
				end
				S_QIW:
				if (mem_ack)
				begin
					// Pending request lives in the base word, not in its address
					qiw_r <= mem_rdata;
					{mem_req_r, mem_addr_r} <= {1'b1, isb_r - HOLD_OFS};
					state_r <= S_HOLD;
				end
				S_HOLD:
				if (mem_ack)
				begin
					mem_req_r <= 1'b1;
					hold_r <= mem_rdata;
					case (kind_r)
						SCHEDULER_ENTRY_OP:
						if (on_interrupt_stack || mem_rdata != 16'h0000)
						begin
							{mem_we_r, mem_addr_r} <= {1'b1, isb_r};
							mem_wdata_r <= qiw_r | (16'h0001 << ISB_PEND);
							st_r <= with_cc(st_r, COND_GREATER_CODE);
							state_r <= S_WBASE;
						end
						else
						begin
							mem_req_r <= 1'b0;
							go_sched_r <= 1'b1;
							st_r <= with_cc(st_r, COND_EQUAL_CODE);
							state_r <= S_WBASE;
						end
						SCHEDULER_HOLD_OP, SCHEDULER_RELEASE_OP:
						begin
							hold_r <= kind_r == SCHEDULER_HOLD_OP ? mem_rdata + 16'h0001
								: mem_rdata - 16'h0001;
							mem_we_r <= 1'b1;
							mem_wdata_r <= kind_r == SCHEDULER_HOLD_OP ? mem_rdata + 16'h0001
								: mem_rdata - 16'h0001;
							state_r <= S_WHOLD;
						end
						default:
						begin
							hold_r <= mem_rdata;
							if (st_r[7:0] != ISR_SEGMENT)
							begin
								mem_addr_r <= q_r + DEV_OFS;
								state_r <= S_DEV;
							end
							else
							begin
								mem_addr_r <= q_r;
								state_r <= S_QW;
							end
						end
					endcase
				end
				S_WHOLD:
				if (mem_ack)
				begin
					mem_we_r <= 1'b0;
					if (kind_r == SCHEDULER_HOLD_OP)
					begin
						{done_r, busy_r} <= 2'b10;
						state_r <= S_IDLE;
					end
					else if (hold_r == 16'h0000 && in_scheduler)
					begin
						// Drops any pending start request
						{mem_req_r, mem_we_r, mem_addr_r, mem_wdata_r} <= {2'b11, isb_r, 16'h0000};
						st_r <= with_cc(st_r, COND_GREATER_CODE);
						state_r <= S_WBASE;
					end
					else if (hold_r == 16'h0000 && !on_interrupt_stack && qiw_r[ISB_PEND])
					begin
						go_sched_r <= 1'b1;
						st_r <= with_cc(st_r, COND_EQUAL_CODE);
						state_r <= S_WBASE;
					end
					else
					begin
						st_r <= with_cc(st_r, COND_GREATER_CODE);
						state_r <= S_WBASE;
					end
				end
				S_DEV:
				if (mem_ack)
				begin
					{rst_r, dev_r} <= {1'b1, mem_rdata};
					{mem_req_r, mem_addr_r} <= {1'b1, q_r};
					state_r <= S_QW;
				end
				S_QW:
				if (mem_ack)
				begin
					state_r <= S_WBASE;
					if (!mem_rdata[QW_SCHED])
						route_r <= q_r == isb_r ? RT_PROCESS : RT_LOWER_INT;
					else if (!qiw_r[ISB_PEND])
						route_r <= RT_SCHED;
					else if (hold_r == 16'h0000)
					begin
						route_r <= RT_DISPATCH;
						go_sched_r <= 1'b1;
						{mem_req_r, mem_we_r, mem_addr_r, mem_wdata_r} <= {2'b11, isb_r, 16'h0000};
					end
					else
						route_r <= q_r == isb_r ? RT_PROCESS : RT_SCHED;
				end
				S_WBASE:
				if (!mem_req_r || mem_ack)
				begin
					mem_we_r <= 1'b0;
					{done_r, busy_r, sched_r} <= {2'b10, go_sched_r};
					commit_r <= kind_r != INTERRUPT_RETURN_OP;
					// Interrupt return commits nothing: keep the last committed values
					if (kind_r != INTERRUPT_RETURN_OP)
					begin
						{np_r, ncb_r, ncl_r, nq_r, ns_r, nx_r} <= {p_r, cb_r, cl_r, q_r, s_r, x_r};
						nst_r <= st_r;
					end
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	assign {mem_req, mem_we, mem_addr, mem_wdata} = {mem_req_r, mem_we_r, mem_addr_r, mem_wdata_r};
	assign {busy, done, commit, trap, trap_kind} = {busy_r, done_r, commit_r, trap_r, trap_kind_r};
	assign {new_p, new_code_base, new_code_limit, new_q} = {np_r, ncb_r, ncl_r, nq_r};
	assign {new_s, new_x, new_status} = {ns_r, nx_r, nst_r};
	assign {sched_entry, route, rst_int, rst_int_dev} = {sched_r, route_r, rst_r, dev_r};

	// Checks
	property p_no_commit_on_trap;
		@(posedge clk) disable iff (reset) trap |-> !commit && done;
	endproperty
	a_no_commit_on_trap: assert property (p_no_commit_on_trap) else $error("commit with trap");

	property p_call_q_s;
		@(posedge clk) disable iff (reset)
			commit && kind_r == PROCEDURE_CALL_OP |-> new_q == new_s && new_s == $past(s_r);
	endproperty
	a_call_q_s: assert property (p_call_q_s) else $error("call pointers differ");

	property p_target_in_window;
		@(posedge clk) disable iff (reset)
			commit && kind_r inside {PROCEDURE_CALL_OP, PROCEDURE_EXIT_OP}
			|-> new_p >= new_code_base && new_p <= new_code_limit;
	endproperty
	a_target_in_window: assert property (p_target_in_window) else $error("target out of window");

	property p_exit_stack;
		@(posedge clk) disable iff (reset)
			commit && kind_r == PROCEDURE_EXIT_OP |-> new_s == q_r - 16'h0004 - {8'h00, n_r};
	endproperty
	a_exit_stack: assert property (p_exit_stack) else $error("exit stack pointer wrong");

	property p_sched_equal;
		@(posedge clk) disable iff (reset)
			sched_entry |-> (commit ? new_status[ST_CC_HI:ST_CC_LO] == COND_EQUAL_CODE
				: kind_r == INTERRUPT_RETURN_OP) && hold_r == 16'h0000;
	endproperty
	a_sched_equal: assert property (p_sched_equal) else $error("scheduler entry bad");

	property p_inhibit_pending;
		@(posedge clk) disable iff (reset)
			state_r == S_HOLD && mem_ack && kind_r == SCHEDULER_ENTRY_OP && mem_rdata != 16'h0000
			|=> mem_req && mem_we && mem_wdata[ISB_PEND] && mem_addr == isb_r;
	endproperty
	a_inhibit_pending: assert property (p_inhibit_pending) else $error("pending bit not set");

	property p_reset_int_seg;
		@(posedge clk) disable iff (reset) rst_int |-> st_r[7:0] != ISR_SEGMENT;
	endproperty
	a_reset_int_seg: assert property (p_reset_int_seg) else $error("reset sent for segment one");

	property p_req_holds;
		@(posedge clk) disable iff (reset) mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
	endproperty
	a_req_holds: assert property (p_req_holds) else $error("request dropped early");

	property p_dispatch_route;
		@(posedge clk) disable iff (reset)
			done && route == RT_DISPATCH |-> sched_entry && $past(mem_we) && $past(mem_wdata) == 16'h0000;
	endproperty
	a_dispatch_route: assert property (p_dispatch_route) else $error("dispatch without clear");

	c_exit_done: cover property (@(posedge clk) disable iff (reset)
		commit && kind_r == PROCEDURE_EXIT_OP);
	c_sched: cover property (@(posedge clk) disable iff (reset) sched_entry);
	c_trap: cover property (@(posedge clk) disable iff (reset) trap);
endmodule
`default_nettype wire

// [tb/prd_mem_model.sv]
// Purpose: word memory standing in for main storage
// Assumes: one access outstanding, request held until ack
// Notes: wait states per access come from the bench
`default_nettype none
module prd_mem_model
(
	// Clock
	input wire logic clk,
	// Access
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata,
	// Wait states
	input wire logic [3:0] lat
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:65535];
	logic [3:0] wait_r = 4'h0;
	logic [15:0] last_r = 16'h0000;
	assign mem_ack = mem_req && (wait_r == lat);
	// Undriven data shows the inverse of the last word, never a stale match
	assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_r;
	always @(posedge clk)
	begin
		wait_r <= (mem_ack || !mem_req) ? 4'h0 : wait_r + 4'h1;
		if (mem_ack)
			last_r <= mem_we ? mem_wdata : mem[mem_addr];
		if (mem_ack && mem_we)
			mem[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

// [tb/test_prd_return_dispatch.sv]
// Purpose: self-checking bench for the return/dispatch sequencer
// Assumes: cpu 2, base word at 0400, segment table at 0800
// Notes: inputs change on the falling edge
`default_nettype none
module test_prd_return_dispatch import prd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset, op_start, interrupt_stack, insch, mem_req, mem_we, mem_ack;
	logic busy, done, commit, trap, sched_entry, rst_int, got_rst;
	prd_op_t op_kind;
	prd_trap_t trap_kind;
	prd_route_t route;
	logic [3:0] lat;
	logic [7:0] op_count, cpu_num;
	logic [15:0] op_label, cp, cb, cl, cq, cs, cx, code_segment_table, mem_addr, mem_wdata, mem_rdata;
	logic [15:0] np, nb, nl, nq, ns, nx, nst, rdev;
	int num_errors = 0;
	int check_count = 0;
	prd_return_dispatch #(.CSEG_BASE(16'h0800)) prd_return_dispatch_inst (.clk(clk),
		.reset(reset), .op_start(op_start), .op_kind(op_kind), .op_count(op_count),
		.op_label(op_label), .cur_p(cp), .cur_code_base(cb), .cur_code_limit(cl),
		.cur_q(cq), .cur_s(cs), .cur_x(cx), .cur_status(code_segment_table), .cpu_num(cpu_num),
		.on_interrupt_stack(interrupt_stack), .in_scheduler(insch), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .busy(busy), .done(done), .commit(commit), .new_p(np),
		.new_code_base(nb), .new_code_limit(nl), .new_q(nq), .new_s(ns), .new_x(nx),
		.new_status(nst), .trap(trap), .trap_kind(trap_kind), .sched_entry(sched_entry),
		.route(route), .rst_int(rst_int), .rst_int_dev(rdev));
	prd_mem_model prd_mem_model_inst (.clk(clk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .lat(lat));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		prd_mem_model_inst.mem[a] = v;
	endtask
	function automatic logic [15:0] rd(input logic [15:0] a);
		return prd_mem_model_inst.mem[a];
	endfunction
	task automatic run_op(input prd_op_t k, input logic [15:0] lbl, input logic [7:0] n);
		int i;
		@(negedge clk);
		op_kind = k;
		op_label = lbl;
		op_count = n;
		op_start = 1'b1;
		@(negedge clk);
		op_start = 1'b0;
		got_rst = 1'b0;
		for (i = 0; i < 300 && done !== 1'b1; i++)
		begin
			got_rst = got_rst | (rst_int === 1'b1);
			@(negedge clk);
		end
		got_rst = got_rst | (rst_int === 1'b1);
		if (i == 300)
		begin
			chk("done", 16'(done), 16'h0001);
			complete_run();
		end
	endtask
	task automatic sc_call();
		lat = 4'h0;
		run_op(PROCEDURE_CALL_OP, 16'h0FFF, 8'h00);
		chk("commit", 16'(commit), 16'h0001);
		chk("p", np, 16'h1FFF);
		chk("q", nq, 16'h0314);
		chk("s", ns, 16'h0314);
		chk("mk_x", rd(16'h0311), 16'hAAAA);
		chk("mk_dp", rd(16'h0312), 16'h0314 - 16'h1235);
		chk("mk_st", rd(16'h0313), 16'h8105);
		chk("mk_dq", rd(16'h0314), 16'h0014);
		run_op(PROCEDURE_CALL_OP, 16'h1000, 8'h00);
		chk("trap", 16'(trap_kind), 16'(TRAP_BOUNDS));
		chk("commit", 16'(commit), 16'h0000);
		chk("p", np, 16'h1FFF);
	endtask
	task automatic ex_case(input logic [15:0] st, ms, dp, fl, input prd_trap_t et,
		input logic [15:0] ep, eb);
		code_segment_table = st;
		wr(16'h081C, fl);
		wr(16'h33FD, 16'h5555);
		wr(16'h33FE, dp);
		wr(16'h33FF, ms);
		wr(16'h3400, 16'h0100);
		run_op(PROCEDURE_EXIT_OP, 16'h0000, 8'h03);
		chk("trap", 16'(trap), 16'(et != TRAP_NONE));
		chk("commit", 16'(commit), 16'(et == TRAP_NONE));
		if (et != TRAP_NONE)
			chk("kind", 16'(trap_kind), 16'(et));
		else
		begin
			chk("p", np, ep);
			chk("pb", nb, eb);
			chk("s", ns, 16'h33F9);
			chk("q", nq, 16'h3300);
			chk("x", nx, 16'h5555);
			chk("st", nst, ms);
		end
	endtask
	task automatic sc_exit();
		lat = 4'h2;
		cb = 16'h4000;
		cl = 16'h4FFF;
		cq = 16'h3400;
		wr(16'h0800, 16'h0010);
		wr(16'h081D, 16'h3000);
		wr(16'h081E, 16'h3FFF);
		ex_case(16'h8005, 16'h8205, 16'hF000, 16'h8000, TRAP_NONE, 16'h4400, 16'h4000);
		ex_case(16'h8005, 16'h8205, 16'h0300, 16'h0000, TRAP_BOUNDS, 0, 0);
		ex_case(16'h0005, 16'h4005, 16'hF000, 16'h0000, TRAP_TAMPER, 0, 0);
		ex_case(16'h0005, 16'h0106, 16'h0100, 16'h4000, TRAP_PRIV, 0, 0);
		ex_case(16'h0005, 16'h0106, 16'h0100, 16'h8000, TRAP_ABSENT, 0, 0);
		ex_case(16'h0005, 16'h0106, 16'h8100, 16'h0000, TRAP_TRACE, 0, 0);
		ex_case(16'h0005, 16'h0106, 16'h0100, 16'h0000, TRAP_NONE, 16'h3300, 16'h3000);
		chk("ref", rd(16'h081C), 16'h2000);
		chk("pl", nl, 16'h3FFF);
		ex_case(16'h8005, 16'h8106, 16'h0100, 16'h4000, TRAP_NONE, 16'h3300, 16'h3000);
	endtask
	task automatic sd_case(input prd_op_t k, input logic ic, sc, input logic [15:0] h, qw,
		input logic es, input logic [1:0] ecc, input logic [15:0] eh);
		interrupt_stack = ic;
		insch = sc;
		wr(16'h03EE, h);
		wr(16'h0400, qw);
		run_op(k, 16'h0000, 8'h00);
		chk("sched", 16'(sched_entry), 16'(es));
		if (k != SCHEDULER_HOLD_OP)
			chk("cc", 16'(nst[9:8]), 16'(ecc));
		chk("hold", rd(16'h03EE), eh);
	endtask
	task automatic sc_sched();
		lat = 4'h1;
		code_segment_table = 16'h8005;
		wr(16'h0009, 16'h0400);
		sd_case(SCHEDULER_HOLD_OP, 0, 0, 16'h0000, 16'h0000, 0, 0, 16'h0001);
		sd_case(SCHEDULER_ENTRY_OP, 0, 0, 16'h0001, 16'h0000, 0, COND_GREATER_CODE, 1);
		chk("qi", rd(16'h0400), 16'h8000);
		sd_case(SCHEDULER_RELEASE_OP, 0, 0, 16'h0001, 16'h8000, 1, COND_EQUAL_CODE, 0);
		sd_case(SCHEDULER_ENTRY_OP, 0, 0, 16'h0000, 16'h0000, 1, COND_EQUAL_CODE, 0);
		sd_case(SCHEDULER_ENTRY_OP, 1, 0, 16'h0000, 16'h0000, 0, COND_GREATER_CODE, 0);
		chk("qi", rd(16'h0400), 16'h8000);
		sd_case(SCHEDULER_RELEASE_OP, 0, 1, 16'h0001, 16'h8000, 0, COND_GREATER_CODE, 0);
		chk("qi", rd(16'h0400), 16'h0000);
		sd_case(SCHEDULER_RELEASE_OP, 0, 0, 16'h0003, 16'h8000, 0, COND_GREATER_CODE, 2);
		sd_case(SCHEDULER_RELEASE_OP, 0, 0, 16'h0001, 16'h0000, 0, COND_GREATER_CODE, 0);
	endtask
	task automatic ir_case(input logic [7:0] seg, input logic [15:0] q, qw, qiw, h,
		input prd_route_t er, input logic erst);
		code_segment_table = {8'h80, seg};
		cq = q;
		wr(16'h03EE, h);
		wr(16'h0400, qiw);
		if (q != 16'h0400)
			wr(q, qw);
		wr(q + 16'h0003, 16'h0033);
		run_op(INTERRUPT_RETURN_OP, 16'h0000, 8'h00);
		chk("route", 16'(route), 16'(er));
		chk("rst", 16'(got_rst), 16'(erst));
		if (erst)
			chk("dev", rdev, 16'h0033);
	endtask
	task automatic sc_iret();
		lat = 4'h3;
		interrupt_stack = 1'b1;
		insch = 1'b0;
		ir_case(8'h05, 16'h0400, 0, 16'h0000, 0, RT_PROCESS, 1);
		ir_case(8'h01, 16'h0420, 0, 16'h0000, 0, RT_LOWER_INT, 0);
		ir_case(8'h01, 16'h0420, 16'h8000, 16'h0000, 0, RT_SCHED, 0);
		ir_case(8'h01, 16'h0420, 16'h8000, 16'h8000, 0, RT_DISPATCH, 0);
		chk("qi", rd(16'h0400), 16'h0000);
		ir_case(8'h01, 16'h0400, 0, 16'h8000, 0, RT_DISPATCH, 0);
		ir_case(8'h01, 16'h0420, 16'h8000, 16'h8000, 2, RT_SCHED, 0);
		chk("qi", rd(16'h0400), 16'h8000);
		ir_case(8'h01, 16'h0400, 0, 16'h8000, 2, RT_PROCESS, 0);
	endtask
	initial
	begin
		reset = 1'b1;
		op_start = 1'b0;
		op_kind = PROCEDURE_CALL_OP;
		op_count = 8'h00;
		op_label = 16'h0000;
		{interrupt_stack, insch, got_rst} = 3'h0;
		lat = 4'h0;
		cpu_num = 8'h02;
		{cp, cb, cl, cq} = {16'h1234, 16'h1000, 16'h1FFF, 16'h0300};
		{cs, cx, code_segment_table} = {16'h0310, 16'hAAAA, 16'h8105};
		repeat (2) @(negedge clk);
		reset = 1'b0;
		chk("busy", 16'(busy), 16'h0000);
		chk("route", 16'(route), 16'(RT_NONE));
		sc_call();
		sc_exit();
		sc_sched();
		sc_iret();
		complete_run();
	end
endmodule
`default_nettype wire
